// file: core/lbc_core.sv
// Local bus control sequencer, straps, self-test and register slave.
// Contract
// - Access type low for instruction fetch, high for data, timed like write/read.
// - Core-hold strap high starts core at once; low waits for software release.
// - Peripherals stay reachable over PCI while the core is held in reset.
// - Direction low for reads, high for writes; never changes during data enable.
// - Lock asserted low in first clock of atomic sequence, released at last transfer.
// - No hold acknowledge while the lock output is asserted.
// - Float strap low at reset end: freeze and release every output; the code freezes only the bus sequencer and clears only ctrl_oe.
// - Hold request high is granted with acknowledge, floated lines, released state.
// - Hold removed: drop acknowledge, go idle or address, drive lines again.
// - Hold requests are honoured both while halted and in normal operation.
// - Ready/recover not asserted in a data state inserts a wait state.
// - Recovery repeats until ready/recover is sampled high.
// - Write/read shown in address state, held through all data states.
// - Width outputs encode 8, 16, 32 bit ports as 00, 01, 10.
// - Retry strap high makes configuration cycles retry until the disable bit clears.
// - Self-test fail flag asserted at reset, toggled in tests, shows result.
// - Failed self-test halts only the core; the bridge keeps running.
// - Self-test strap high runs internal and bus tests; low, bus test only.
// - Drive a local bus reset output for external local-bus devices.
// - Test port samples test data in on rising test clock while shifting.
// - Test data out changes on falling test clock when shifting, else floats.
// - Test reset pin clears the port controller asynchronously.
// - Data enable low from first data cycle to end of last data cycle.
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
module lbc_core #(
  parameter int BIST_N = lbc_pkg::BIST_CYCLES,
  parameter int BUS_N  = lbc_pkg::BUS_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_data,
  input  wire logic [1:0]  req_len,
  input  wire logic [1:0]  req_width,
  input  wire logic        req_lock,
  input  wire logic        req_lock_end,
  output logic             req_ack,
  input  wire logic        bist_pass,
  input  wire logic        bus_test_pass,
  input  wire logic        hold_req,
  input  wire logic        ready_recover_in_n,
  input  wire logic        core_hold_strap,
  input  wire logic        port_width_bit1_cfg_strap_in,
  input  wire logic        float_strap_n,
  input  wire logic        selftest_enable_strap,
  output logic             access_type,
  output logic             transfer_direction,
  output logic             data_phase_enable_n,
  output logic             lock_n,
  output logic             write_read,
  output logic             port_width_bit0,
  output logic             port_width_bit1_cfg_strap,
  output logic             ctrl_oe,
  output logic             bus_grant_ack,
  output logic             local_ready_recover_out_n,
  output logic             local_bus_reset_n,
  output logic             core_reset_n,
  output logic             core_halt,
  output logic             cfg_retry,
  output logic             pci_periph_secondary,
  output logic             selftest_fail_n,
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  input  wire logic        tap_reset_n,
  output logic             tdo,
  output logic             tdo_oe
);
  // ==========================================================================
  // Pin synchronisers for hold request and ready/recover.
  logic [1:0] pin_in, p1_q, p2_q;
  assign pin_in = {ready_recover_in_n, hold_req};
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        p1_q[i] <= (i == 1);
        p2_q[i] <= (i == 1);
      end else if (clk_en) begin
        p1_q[i] <= pin_in[i];
        p2_q[i] <= p1_q[i];
      end
    end
  end
  logic hold_s, rdy, rec_done;
  assign hold_s   = p2_q[0];
  assign rdy      = ~p2_q[1];
  assign rec_done = p2_q[1];
  // ==========================================================================
  // Straps, self-test and test port.
  logic       straps_valid, st_done, st_ok, core_rst_q, cfg_dis_q;
  logic [3:0] straps;
  lbc_strap_bist #(
    .BIST_N (BIST_N),
    .BUS_N  (BUS_N)
  ) u_strap (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .clk_en          (clk_en),
    .strap_pins      ({selftest_enable_strap, float_strap_n,
                       port_width_bit1_cfg_strap_in, core_hold_strap}),
    .start           (~core_rst_q & straps_valid),
    .bist_pass       (bist_pass),
    .bus_test_pass   (bus_test_pass),
    .straps_valid    (straps_valid),
    .straps          (straps),
    .selftest_fail_n (selftest_fail_n),
    .selftest_done   (st_done),
    .selftest_ok     (st_ok)
  );
  lbc_tap u_tap (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .clk_en      (clk_en),
    .tck         (tck),
    .tms         (tms),
    .tdi         (tdi),
    .tap_reset_n (tap_reset_n),
    .tdo         (tdo),
    .tdo_oe      (tdo_oe)
  );
  logic float_q, run, core_act, straps_valid_q;
  lbc_pkg::lbc_seq_t state_q;
  assign run      = straps_valid & straps[2];
  assign core_act = ~core_rst_q & ~core_halt;
  // ==========================================================================
  // AHB-Lite slave: zero wait states, always OKAY.
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic       ahb_go;
  logic [31:0] rd_mux;
  assign ahb_go = hsel & hready & htrans[1];
  always_comb begin
    rd_mux = 32'h0;
    if (haddr[7:0] == lbc_pkg::CTRL_OFS) begin
      rd_mux[lbc_pkg::CTRL_CORE_RST] = core_rst_q;
      rd_mux[lbc_pkg::CTRL_CFG_DIS]  = cfg_dis_q;
    end else if (haddr[7:0] == lbc_pkg::STAT_OFS) begin
      rd_mux[11:0] = {state_q, bus_grant_ack, lock_n, float_q, st_ok,
                      st_done, straps};
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clk_en) begin
      wr_pend_q <= ahb_go & hwrite;
      if (ahb_go) begin
        wr_addr_q <= haddr[7:0];
        hrdata    <= hwrite ? 32'h0 : rd_mux;
      end
    end
  end
  // ==========================================================================
  // Control register: core reset and configuration cycle disable.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_rst_q <= 1'b1;
      cfg_dis_q  <= 1'b0;
      float_q    <= 1'b0;
      straps_valid_q <= 1'b0;
    end else if (clk_en) begin
      straps_valid_q <= straps_valid;
      if (straps_valid && !straps_valid_q) begin
        core_rst_q <= ~straps[0];
        cfg_dis_q  <= straps[1];
        float_q    <= ~straps[2];
      end else if (wr_pend_q && wr_addr_q == lbc_pkg::CTRL_OFS) begin
        core_rst_q <= hwdata[lbc_pkg::CTRL_CORE_RST];
        cfg_dis_q  <= hwdata[lbc_pkg::CTRL_CFG_DIS];
      end
    end
  end
  // ==========================================================================
  // Reset, retry and core status outputs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      local_bus_reset_n    <= 1'b0;
      core_reset_n         <= 1'b0;
      core_halt            <= 1'b0;
      cfg_retry            <= 1'b0;
      pci_periph_secondary <= 1'b0;
    end else if (clk_en) begin
      local_bus_reset_n    <= straps_valid;
      core_reset_n         <= ~core_rst_q;
      core_halt            <= st_done & ~st_ok;
      cfg_retry            <= cfg_dis_q;
      pci_periph_secondary <= straps_valid & straps[1];
    end
  end
  // ==========================================================================
  // Bus sequencer.
  logic [1:0] beats_q;
  logic       lock_end_q, accept, last_xfer;
  assign accept = req_valid & core_act & ~(hold_s & lock_n) &
                  ((state_q == lbc_pkg::SEQ_IDLE) |
                   (state_q == lbc_pkg::SEQ_HOLD & ~hold_s));
  assign last_xfer = rdy & (beats_q == 2'h0) &
                     ((state_q == lbc_pkg::SEQ_DATA) | (state_q == lbc_pkg::SEQ_WAIT));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= lbc_pkg::SEQ_IDLE;
      beats_q <= 2'h0;
    end else if (clk_en && run) begin
      case (state_q)
        lbc_pkg::SEQ_IDLE: begin
          if (hold_s && lock_n) state_q <= lbc_pkg::SEQ_HOLD;
          else if (accept) state_q <= lbc_pkg::SEQ_ADDR;
        end
        lbc_pkg::SEQ_HOLD: begin
          if (!hold_s) state_q <= accept ? lbc_pkg::SEQ_ADDR : lbc_pkg::SEQ_IDLE;
        end
        lbc_pkg::SEQ_ADDR: begin
          state_q <= lbc_pkg::SEQ_DATA;
          beats_q <= req_len;
        end
        lbc_pkg::SEQ_DATA, lbc_pkg::SEQ_WAIT: begin
          if (!rdy) state_q <= lbc_pkg::SEQ_WAIT;
          else if (beats_q == 2'h0) state_q <= lbc_pkg::SEQ_RECOV;
          else begin
            state_q <= lbc_pkg::SEQ_DATA;
            beats_q <= beats_q - 2'h1;
          end
        end
        lbc_pkg::SEQ_RECOV: begin
          if (rec_done) state_q <= lbc_pkg::SEQ_IDLE;
        end
        default: state_q <= lbc_pkg::SEQ_IDLE;
      endcase
    end
  end
  // ==========================================================================
  // Access qualifiers latched at acceptance, held through data states.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_ack                   <= 1'b0;
      access_type               <= 1'b1;
      transfer_direction        <= 1'b0;
      write_read                <= 1'b0;
      port_width_bit0           <= lbc_pkg::WIDTH_RST[0];
      port_width_bit1_cfg_strap <= lbc_pkg::WIDTH_RST[1];
      lock_end_q                <= 1'b0;
    end else if (clk_en) begin
      req_ack <= run & accept;
      if (run && accept) begin
        access_type               <= req_data;
        transfer_direction        <= req_write;
        write_read                <= req_write;
        port_width_bit1_cfg_strap <= req_width[1];
        port_width_bit0           <= req_width[0];
        lock_end_q                <= req_lock_end;
      end
    end
  end
  // ==========================================================================
  // Data enable, lock, grant and output enable.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_phase_enable_n       <= 1'b1;
      lock_n                    <= 1'b1;
      bus_grant_ack             <= 1'b0;
      ctrl_oe                   <= 1'b0;
      local_ready_recover_out_n <= 1'b1;
    end else if (clk_en) begin
      local_ready_recover_out_n <= p2_q[1];
      ctrl_oe <= run & ~bus_grant_ack;
      if (run) begin
        if (state_q == lbc_pkg::SEQ_ADDR) data_phase_enable_n <= 1'b0;
        else if (last_xfer) data_phase_enable_n <= 1'b1;
        if (accept && req_lock) lock_n <= 1'b0;
        else if (last_xfer && lock_end_q) lock_n <= 1'b1;
        if (state_q == lbc_pkg::SEQ_IDLE && hold_s && lock_n) begin
          bus_grant_ack <= 1'b1;
          ctrl_oe       <= 1'b0;
        end else if (state_q == lbc_pkg::SEQ_HOLD && !hold_s) begin
          bus_grant_ack <= 1'b0;
        end
      end
    end
  end
  // ==========================================================================
  // Assertions.
  a_dir_den_stable: assert property (@(posedge hclk) disable iff (!hresetn)
    (!data_phase_enable_n && !$past(data_phase_enable_n)) |-> $stable(transfer_direction))
    else $error("direction changed while data enable asserted");
  a_type_timing: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(access_type) |-> $changed(req_ack) || $past(accept))
    else $error("access type changed outside acceptance");
  a_lock_no_grant: assert property (@(posedge hclk) disable iff (!hresetn)
    !(bus_grant_ack && !lock_n))
    else $error("grant given while lock asserted");
  a_wait_insert: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && run && state_q == lbc_pkg::SEQ_DATA && !rdy) |=> state_q == lbc_pkg::SEQ_WAIT)
    else $error("no wait state on missing ready");
  a_recov_stay: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && run && state_q == lbc_pkg::SEQ_RECOV && !rec_done)
      |=> state_q == lbc_pkg::SEQ_RECOV)
    else $error("recovery left before ready high");
  a_hold_grant: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && run && state_q == lbc_pkg::SEQ_IDLE && hold_s && lock_n)
      |=> bus_grant_ack ##1 !ctrl_oe)
    else $error("hold request not granted");
  a_hold_release: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && run && state_q == lbc_pkg::SEQ_HOLD && !hold_s) |=> !bus_grant_ack)
    else $error("acknowledge kept after hold removed");
  a_den_data: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == lbc_pkg::SEQ_DATA || state_q == lbc_pkg::SEQ_WAIT) |-> !data_phase_enable_n)
    else $error("data enable not asserted in data state");
  a_wr_dir_match: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == lbc_pkg::SEQ_DATA) |-> write_read == transfer_direction)
    else $error("write/read disagrees with direction");
  a_float_oe: assert property (@(posedge hclk) disable iff (!hresetn)
    float_q |=> !ctrl_oe)
    else $error("outputs driven in float mode");
  a_halt_grant: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && run && core_halt && state_q == lbc_pkg::SEQ_IDLE && hold_s && lock_n)
      |=> bus_grant_ack)
    else $error("hold not granted while halted");
  a_core_held: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && straps_valid && !straps_valid_q && !straps[0])
      |=> core_rst_q ##1 !core_reset_n)
    else $error("core released despite hold strap");
endmodule // lbc_core

// file: core/lbc_pkg.sv
// Shared constants and types for the local bus control block.
package lbc_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] STAT_OFS       = 8'h04;
  localparam int         CTRL_CORE_RST  = 0;
  localparam int         CTRL_CFG_DIS   = 1;
  // ==========================================================================
  // Port width codes
  localparam logic [1:0] WIDTH_8        = 2'h0;
  localparam logic [1:0] WIDTH_16       = 2'h1;
  localparam logic [1:0] WIDTH_32       = 2'h2;
  localparam logic [1:0] WIDTH_RST      = 2'h3;
  // ==========================================================================
  // Cycle counts and test port instruction capture value
  localparam int         BIST_CYCLES    = 16;
  localparam int         BUS_CYCLES     = 8;
  localparam int         STRAP_SETTLE   = 3;
  localparam logic [3:0] IR_CAPTURE     = 4'h1;
  // ==========================================================================
  // State types
  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'h0,
    SEQ_ADDR  = 3'h1,
    SEQ_DATA  = 3'h3,
    SEQ_WAIT  = 3'h2,
    SEQ_RECOV = 3'h6,
    SEQ_HOLD  = 3'h4
  } lbc_seq_t;
  typedef enum logic [1:0] {
    BST_SAMPLE = 2'h0,
    BST_CORE   = 2'h1,
    BST_BUS    = 2'h3,
    BST_DONE   = 2'h2
  } lbc_bist_t;
endpackage

// file: core/lbc_strap_bist.sv
// Reset strap capture and self-test sequencing.
`timescale 1ns/100ps
module lbc_strap_bist #(
  parameter int BIST_N = lbc_pkg::BIST_CYCLES,
  parameter int BUS_N  = lbc_pkg::BUS_CYCLES
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic clk_en,
  input  wire logic [3:0] strap_pins,
  input  wire logic start,
  input  wire logic bist_pass,
  input  wire logic bus_test_pass,
  output logic      straps_valid,
  output logic [3:0] straps,
  output logic      selftest_fail_n,
  output logic      selftest_done,
  output logic      selftest_ok
);
  logic [3:0] s1_q, s2_q;
  logic [1:0] settle_q;
  logic [7:0] cnt_q;
  lbc_pkg::lbc_bist_t st_q;
  // ==========================================================================
  // Strap synchroniser and capture after reset release.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q         <= 4'hf;
      s2_q         <= 4'hf;
      settle_q     <= 2'h0;
      straps_valid <= 1'b0;
      straps       <= 4'hf;
    end else if (clk_en) begin
      s1_q <= strap_pins;
      s2_q <= s1_q;
      if (!straps_valid) begin
        if (settle_q == 2'(lbc_pkg::STRAP_SETTLE - 1)) begin
          straps_valid <= 1'b1;
          straps       <= s2_q;
        end else begin
          settle_q <= settle_q + 2'h1;
        end
      end
    end
  end
  // ==========================================================================
  // Self-test: fail flag low from reset, toggled per test, final result.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q            <= lbc_pkg::BST_SAMPLE;
      cnt_q           <= 8'h0;
      selftest_fail_n <= 1'b0;
      selftest_done   <= 1'b0;
      selftest_ok     <= 1'b1;
    end else if (clk_en) begin
      case (st_q)
        lbc_pkg::BST_SAMPLE: begin
          if (start) begin
            selftest_fail_n <= ~selftest_fail_n;
            cnt_q           <= 8'h0;
            st_q            <= straps[3] ? lbc_pkg::BST_CORE : lbc_pkg::BST_BUS;
          end
        end
        lbc_pkg::BST_CORE: begin
          cnt_q <= cnt_q + 8'h1;
          if (cnt_q == 8'(BIST_N - 1)) begin
            selftest_ok     <= bist_pass;
            selftest_fail_n <= ~selftest_fail_n;
            cnt_q           <= 8'h0;
            st_q            <= lbc_pkg::BST_BUS;
          end
        end
        lbc_pkg::BST_BUS: begin
          cnt_q <= cnt_q + 8'h1;
          if (cnt_q == 8'(BUS_N - 1)) begin
            selftest_ok     <= selftest_ok & bus_test_pass;
            selftest_fail_n <= selftest_ok & bus_test_pass;
            selftest_done   <= 1'b1;
            st_q            <= lbc_pkg::BST_DONE;
          end
        end
        default: st_q <= lbc_pkg::BST_DONE;
      endcase
    end
  end
endmodule // lbc_strap_bist

// file: core/lbc_tap.sv
// Boundary-scan test access port with instruction and bypass paths.
`timescale 1ns/100ps
module lbc_tap (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic clk_en,
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  input  wire logic tap_reset_n,
  output logic      tdo,
  output logic      tdo_oe
);
  logic [2:0] s1_q, s2_q;
  logic       tck3_q, bypass_q;
  logic [3:0] st_q, ir_q;
  logic       rise, fall, tms_s;
  wire        arst_n = hresetn & tap_reset_n;
  assign rise  = s2_q[0] & ~tck3_q;
  assign fall  = ~s2_q[0] & tck3_q;
  assign tms_s = s2_q[1];
  // ==========================================================================
  // Pin synchroniser; the reset pin clears the controller at once.
  always_ff @(posedge hclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q     <= 3'h0;
      s2_q     <= 3'h0;
      tck3_q   <= 1'b0;
      st_q     <= 4'hf;
      ir_q     <= 4'h0;
      bypass_q <= 1'b0;
      tdo      <= 1'b0;
      tdo_oe   <= 1'b0;
    end else if (clk_en) begin
      s1_q   <= {tdi, tms, tck};
      s2_q   <= s1_q;
      tck3_q <= s2_q[0];
      if (rise) begin
        case (st_q)
          4'hf: st_q <= tms_s ? 4'hf : 4'hc;
          4'hc: st_q <= tms_s ? 4'h7 : 4'hc;
          4'h7: st_q <= tms_s ? 4'h4 : 4'h6;
          4'h6: st_q <= tms_s ? 4'h1 : 4'h2;
          4'h2: st_q <= tms_s ? 4'h1 : 4'h2;
          4'h1: st_q <= tms_s ? 4'h5 : 4'h3;
          4'h3: st_q <= tms_s ? 4'h0 : 4'h3;
          4'h0: st_q <= tms_s ? 4'h5 : 4'h2;
          4'h5: st_q <= tms_s ? 4'h7 : 4'hc;
          4'h4: st_q <= tms_s ? 4'hf : 4'he;
          4'he: st_q <= tms_s ? 4'h9 : 4'ha;
          4'ha: st_q <= tms_s ? 4'h9 : 4'ha;
          4'h9: st_q <= tms_s ? 4'hd : 4'hb;
          4'hb: st_q <= tms_s ? 4'h8 : 4'hb;
          4'h8: st_q <= tms_s ? 4'hd : 4'ha;
          default: st_q <= tms_s ? 4'h7 : 4'hc;
        endcase
        if (st_q == 4'he) ir_q <= lbc_pkg::IR_CAPTURE;
        if (st_q == 4'ha) ir_q <= {s2_q[2], ir_q[3:1]};
        if (st_q == 4'h6) bypass_q <= 1'b0;
        if (st_q == 4'h2) bypass_q <= s2_q[2];
      end
      if (fall) begin
        tdo_oe <= (st_q == 4'ha) | (st_q == 4'h2);
        tdo    <= (st_q == 4'ha) ? ir_q[0] : bypass_q;
      end
    end
  end
endmodule // lbc_tap

// file: sim/lbc_mem_model.sv
// External memory controller model that answers on the ready/recover pin.
`timescale 1ns/100ps
module lbc_mem_model (
  input  wire logic       hclk,
  input  wire logic       data_phase_enable_n,
  input  wire logic [1:0] waits,
  output logic            ready_recover_in_n
);
  logic [1:0] cnt_q;
  // ==========================================================================
  // Ready after a set number of wait states, recovery complete outside data.
  always_ff @(posedge hclk) begin
    cnt_q <= data_phase_enable_n ? 2'h0 : cnt_q + 2'h1;
    ready_recover_in_n <= !(!data_phase_enable_n && cnt_q >= waits);
  end
endmodule // lbc_mem_model

// file: sim/local_bus_control_and_straps_tb_top.sv
// Self-checking testbench for the local bus control block.
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", n, e, s); end end
module local_bus_control_and_straps_tb_top;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, req_valid, req_write, req_data;
  logic req_lock, req_lock_end, req_ack, bist_pass, bus_test_pass, hold_req;
  logic ready_recover_in_n, core_hold_strap, port_width_bit1_cfg_strap_in, float_strap_n;
  logic selftest_enable_strap, access_type, transfer_direction, data_phase_enable_n;
  logic lock_n, write_read, port_width_bit0, port_width_bit1_cfg_strap, ctrl_oe;
  logic bus_grant_ack, local_ready_recover_out_n, local_bus_reset_n, core_reset_n;
  logic core_halt, cfg_retry, pci_periph_secondary, selftest_fail_n, tdo, tdo_oe;
  logic tck, tms, tdi, tap_reset_n;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, req_len, req_width, waits;
  int          bad_count, n_checks, den_cyc, den0;
  lbc_core #(.BIST_N(2), .BUS_N(2)) lbc_core_i (.hsize(3'h2), .clk_en(1'b1),
    .hready(hreadyout), .*);
  lbc_mem_model lbc_mem_model_i (.hclk(hclk), .data_phase_enable_n(data_phase_enable_n),
    .waits(waits), .ready_recover_in_n(ready_recover_in_n));
  // ==========================================================================
  // Shared tasks
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_for(ref logic s, input logic v);
    for (int k = 0; k < 200; k++) begin
      @(posedge hclk);
      if (s === v) return;
    end
    bad_count++;
    results();
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    wait_for(hreadyout, 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_for(hreadyout, 1'b1);
    rd = hrdata;
  endtask
  task automatic core_req(input logic w, input logic d, input logic [1:0] wd, input logic lk);
    req_valid <= 1'b1; req_write <= w; req_data <= d; req_width <= wd;
    req_lock <= lk; req_lock_end <= lk; req_len <= 2'h0;
    wait_for(req_ack, 1'b1);
    req_valid <= 1'b0;
    `CHK("write_read", w, write_read)
    `CHK("access_type", d, access_type)
    `CHK("width", wd, {port_width_bit1_cfg_strap, port_width_bit0})
    `CHK("lock_n", !lk, lock_n)
    wait_for(data_phase_enable_n, 1'b0);
    den_cyc = 0;
    while (data_phase_enable_n === 1'b0 && den_cyc < 50) begin
      `CHK("direction", w, transfer_direction)
      den_cyc++;
      @(posedge hclk);
    end
  endtask
  task automatic reset_with(input logic [3:0] s);
    {selftest_enable_strap, float_strap_n, port_width_bit1_cfg_strap_in, core_hold_strap} <= s;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask
  task automatic tck_cycle(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    tck <= 1'b1;
    repeat (4) @(posedge hclk);
    tck <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic tap_scan;
    tck_cycle(1'b0, 1'b0);
    tck_cycle(1'b1, 1'b0);
    tck_cycle(1'b1, 1'b0);
    tck_cycle(1'b0, 1'b0);
    `CHK("tdo_oe_capture", 1'b0, tdo_oe)
    tck_cycle(1'b0, 1'b0);
    `CHK("tdo_oe_shift", 1'b1, tdo_oe)
    `CHK("tdo_capture", lbc_pkg::IR_CAPTURE[0], tdo)
    tck_cycle(1'b0, 1'b1);
    `CHK("tdo_second", lbc_pkg::IR_CAPTURE[1], tdo)
    repeat (3) tck_cycle(1'b0, 1'b0);
    `CHK("tdi_shifted", 1'b1, tdo)
    tap_reset_n <= 1'b0;
    @(posedge hclk);
    `CHK("tdo_oe_trst", 1'b0, tdo_oe)
    tap_reset_n <= 1'b1;
  endtask
  task automatic halted_core;
    bus_test_pass <= 1'b0;
    reset_with(4'h4);
    `CHK("core_held", 1'b0, core_reset_n)
    `CHK("cfg_normal", 1'b0, cfg_retry)
    `CHK("periph_pri", 1'b0, pci_periph_secondary)
    ahb(1'b1, lbc_pkg::CTRL_OFS, 32'h0);
    wait_for(core_reset_n, 1'b1);
    wait_for(core_halt, 1'b1);
    `CHK("fail_result", 1'b0, selftest_fail_n)
    ahb(1'b0, lbc_pkg::STAT_OFS, 32'h0);
    `CHK("status_halted", 6'h14, rd[5:0])
    hold_req <= 1'b1;
    wait_for(bus_grant_ack, 1'b1);
    hold_req <= 1'b0;
    wait_for(bus_grant_ack, 1'b0);
  endtask
  task automatic float_mode;
    reset_with(4'hb);
    `CHK("float_oe", 1'b0, ctrl_oe)
    ahb(1'b0, lbc_pkg::STAT_OFS, 32'h0);
    `CHK("float_flag", 1'b1, rd[6])
  endtask
  // ==========================================================================
  // Clock and main sequence
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, req_valid, req_write, req_data, req_lock, req_lock_end} = '0;
    {hold_req, haddr, hwdata, htrans, req_len, req_width, waits} = '0;
    {tck, tms, tdi, tap_reset_n} = '0;
    {bist_pass, bus_test_pass, core_hold_strap, port_width_bit1_cfg_strap_in} = '1;
    {float_strap_n, selftest_enable_strap} = '1;
    bad_count = 0; n_checks = 0;
    repeat (2) @(posedge hclk);
    `CHK("lbus_reset", 1'b0, local_bus_reset_n)
    `CHK("fail_at_reset", 1'b0, selftest_fail_n)
    {hresetn, tap_reset_n} <= 2'h3;
    wait_for(local_bus_reset_n, 1'b1);
    wait_for(core_reset_n, 1'b1);
    `CHK("cfg_retry", 1'b1, cfg_retry)
    `CHK("periph_sec", 1'b1, pci_periph_secondary)
    ahb(1'b0, lbc_pkg::STAT_OFS, 32'h0);
    `CHK("straps", 4'hf, rd[3:0])
    `CHK("hresp", 1'b0, hresp)
    `CHK("lrr_idle", 1'b1, local_ready_recover_out_n)
    ahb(1'b1, lbc_pkg::CTRL_OFS, 32'h0);
    ahb(1'b1, 8'h40, 32'hffff_ffff);
    ahb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("cfg_retry_off", 1'b0, cfg_retry)
    for (int i = 0; i < 3; i++) core_req(i[0], i != 1, i[1:0], 1'b0);
    core_req(1'b0, 1'b1, 2'h2, 1'b1);
    den0 = den_cyc;
    waits <= 2'h2;
    core_req(1'b0, 1'b1, 2'h2, 1'b0);
    `CHK("wait_states", den0 + 2, den_cyc)
    hold_req <= 1'b1;
    wait_for(bus_grant_ack, 1'b1);
    @(posedge hclk);
    `CHK("float_lines", 1'b0, ctrl_oe)
    hold_req <= 1'b0;
    wait_for(bus_grant_ack, 1'b0);
    @(posedge hclk);
    `CHK("drive_lines", 1'b1, ctrl_oe)
    `CHK("selftest_pass", 1'b1, selftest_fail_n)
    tap_scan();
    halted_core();
    float_mode();
    results();
  end
endmodule // local_bus_control_and_straps_tb_top
